// File: design/spp_map.svh
`ifndef SPP_MAP_SVH
`define SPP_MAP_SVH

// Control and format bit positions
`define SPP_CTRL_SEL_BIT 0
`define SPP_FMT_PHASE_BIT 16
`define SPP_FMT_POL_BIT 17
`define SPP_FMT_PS_MSB 15
`define SPP_FMT_PS_LSB 8

// Word and counter sizes
`define SPP_WORD_BITS 16
`define SPP_PER_BITS 9

// Reset values
`define SPP_WORD_RST 16'h0000
`define SPP_PER_RST 9'h000

// Timing: figures in ns, minimum count derived from the 100 MHz clock, prescale-0 count fixed
`define SPP_CLK_PERIOD_NS 10
`define SPP_MIN_PERIOD_NS 25
`define SPP_MIN_PERIOD_CYC ((`SPP_MIN_PERIOD_NS + `SPP_CLK_PERIOD_NS - 1) / `SPP_CLK_PERIOD_NS)
`define SPP_PS0_PERIOD_CYC 2

`endif

// File: design/spp_pkg.sv
package spp_pkg;

	typedef struct packed {
		logic cpol;
		logic cpha;
		logic [7:0] prescale;
	} spp_fmt_t;

	typedef struct packed {
		logic [15:0] data;
		logic valid;
	} spp_rx_t;

	typedef enum logic [1:0] {
		SPP_IDLE = 2'b01,
		SPP_ACTIVE = 2'b10
	} spp_state_t;

endpackage

// File: design/spp_sync.sv
`timescale 1ns/100ps
module spp_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			logic meta_r;
			logic hold_r;
			always_ff @(posedge clk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					meta_r <= 1'b0;
					hold_r <= 1'b0;
				end
				else
				begin
					meta_r <= async_in[i];
					hold_r <= meta_r;
				end
			end
			assign sync_out[i] = hold_r;
		end
	endgenerate

endmodule

// File: design/spp_port.sv
// Behaviour
// - Peripheral mode while controller-select bit cleared
// - Format bit 16 selects clock phase
// - Format bit 17 selects clock polarity
// - Host clock period bounded by prescale, 25ns; prescale 0 flags every period
// - Launch rising when polarity equals phase
// - Sample falling when polarity equals phase
`timescale 1ns/100ps
`include "spp_map.svh"
module spp_port (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [31:0] global_control_reg,
	input wire logic [31:0] format_reg,
	input wire logic serial_clock_in,
	input wire logic chip_select_n,
	input wire logic host_to_device_data,
	output logic device_to_host_data,
	output logic device_to_host_data_oe,
	input wire logic [15:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic [15:0] rx_data,
	output logic rx_valid,
	output logic tx_underrun,
	output logic period_err,
	input wire logic err_clr
);

	logic [2:0] pins_s;
	logic sck_s;
	logic cs_n_s;
	logic sdi_s;
	spp_pkg::spp_fmt_t fmt;
	logic enabled;
	logic selected;
	logic sck_rise;
	logic sck_fall;
	logic launch_edge;
	logic sample_edge;
	logic [8:0] req_cyc;
	logic [8:0] period_cyc;
	logic period_bad;

	spp_pkg::spp_state_t state_r;
	spp_pkg::spp_state_t state_nxt;
	logic sck_d_r;
	logic sck_d_nxt;
	logic [3:0] bit_cnt_r;
	logic [3:0] bit_cnt_nxt;
	logic [15:0] tx_sh_r;
	logic [15:0] tx_sh_nxt;
	logic [15:0] rx_sh_r;
	logic [15:0] rx_sh_nxt;
	logic out_r;
	logic out_nxt;
	logic oe_r;
	logic oe_nxt;
	spp_pkg::spp_rx_t rx_r;
	spp_pkg::spp_rx_t rx_nxt;
	logic [15:0] buf_r;
	logic [15:0] buf_nxt;
	logic buf_full_r;
	logic buf_full_nxt;
	logic under_r;
	logic under_nxt;
	logic [8:0] per_cnt_r;
	logic [8:0] per_cnt_nxt;
	logic seen_r;
	logic seen_nxt;
	logic err_r;
	logic err_nxt;

	// Pins come from the host clock domain
	spp_sync #(
		.WIDTH(3)
	) u_sync (
		.clk(clk),
		.arst_n(arst_n),
		// Select enters inverted so the flops' reset level reads as deselected
		.async_in({serial_clock_in, !chip_select_n, host_to_device_data}),
		.sync_out(pins_s)
	);

	assign sck_s = pins_s[2];
	assign cs_n_s = !pins_s[1];
	assign sdi_s = pins_s[0];

	always_comb
	begin
		fmt.cpha = format_reg[`SPP_FMT_PHASE_BIT];
		fmt.cpol = format_reg[`SPP_FMT_POL_BIT];
		fmt.prescale = format_reg[`SPP_FMT_PS_MSB:`SPP_FMT_PS_LSB];
	end

	assign enabled = !global_control_reg[`SPP_CTRL_SEL_BIT];
	assign selected = enabled && !cs_n_s;
	assign sck_rise = sck_s && !sck_d_r;
	assign sck_fall = !sck_s && sck_d_r;
	// Polarity sets which level is idle, so the edge choice follows both bits
	assign launch_edge = (fmt.cpol == fmt.cpha) ? sck_rise : sck_fall;
	assign sample_edge = (fmt.cpol == fmt.cpha) ? sck_fall : sck_rise;

	// Period check; two synchroniser stages blur each edge by a cycle, so
	// this flags gross violations rather than measuring to the nanosecond
	always_comb
	begin
		req_cyc = (fmt.prescale == 8'h00) ? 9'(`SPP_PS0_PERIOD_CYC) : {1'b0, fmt.prescale} + 9'h001;
		if (req_cyc < 9'(`SPP_MIN_PERIOD_CYC))
		begin
			req_cyc = 9'(`SPP_MIN_PERIOD_CYC);
		end
		period_cyc = per_cnt_r + 9'h001;
		period_bad = (period_cyc < req_cyc) ||
			((fmt.prescale == 8'h00) && (period_cyc != 9'(`SPP_PS0_PERIOD_CYC)));
	end

	assign tx_ready = !buf_full_r;

	always_comb
	begin
		state_nxt = state_r;
		sck_d_nxt = sck_s;
		bit_cnt_nxt = bit_cnt_r;
		tx_sh_nxt = tx_sh_r;
		rx_sh_nxt = rx_sh_r;
		out_nxt = out_r;
		oe_nxt = 1'b0;
		rx_nxt.data = rx_r.data;
		rx_nxt.valid = 1'b0;
		buf_nxt = buf_r;
		buf_full_nxt = buf_full_r;
		under_nxt = 1'b0;
		per_cnt_nxt = per_cnt_r;
		seen_nxt = seen_r;
		err_nxt = err_r && !err_clr;
		case (state_r)
			spp_pkg::SPP_IDLE:
			begin
				if (selected)
				begin
					// Frame start: counter restarts and the next word is taken
					state_nxt = spp_pkg::SPP_ACTIVE;
					bit_cnt_nxt = 4'h0;
					per_cnt_nxt = `SPP_PER_RST;
					seen_nxt = 1'b0;
					oe_nxt = 1'b1;
					tx_sh_nxt = buf_full_r ? buf_r : `SPP_WORD_RST;
					buf_full_nxt = 1'b0;
					under_nxt = !buf_full_r;
					if (fmt.cpha)
					begin
						// Phase 1: first edge samples, so the first bit leads
						out_nxt = tx_sh_nxt[15];
						tx_sh_nxt = {tx_sh_nxt[14:0], 1'b0};
					end
				end
			end
			spp_pkg::SPP_ACTIVE:
			begin
				if (!selected)
				begin
					state_nxt = spp_pkg::SPP_IDLE;
				end
				else
				begin
					oe_nxt = 1'b1;
					if (per_cnt_r != 9'h1ff)
					begin
						per_cnt_nxt = per_cnt_r + 9'h001;
					end
					if (sck_rise)
					begin
						per_cnt_nxt = `SPP_PER_RST;
						seen_nxt = 1'b1;
						if (seen_r && period_bad)
						begin
							err_nxt = 1'b1;
						end
					end
					if (launch_edge)
					begin
						out_nxt = tx_sh_r[15];
						tx_sh_nxt = {tx_sh_r[14:0], 1'b0};
					end
					if (sample_edge)
					begin
						rx_sh_nxt = {rx_sh_r[14:0], sdi_s};
						bit_cnt_nxt = bit_cnt_r + 4'h1;
						if (bit_cnt_r == 4'(`SPP_WORD_BITS - 1))
						begin
							// A host that keeps select low simply streams words
							rx_nxt.data = {rx_sh_r[14:0], sdi_s};
							rx_nxt.valid = 1'b1;
							tx_sh_nxt = buf_full_r ? buf_r : `SPP_WORD_RST;
							buf_full_nxt = 1'b0;
							under_nxt = !buf_full_r;
						end
					end
				end
			end
			default:
			begin
				state_nxt = spp_pkg::SPP_IDLE;
			end
		endcase
		// Accept after any reload, so a word taken at a load cycle is kept
		if (tx_valid && tx_ready)
		begin
			buf_nxt = tx_data;
			buf_full_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_r <= spp_pkg::SPP_IDLE;
			sck_d_r <= 1'b0;
			bit_cnt_r <= 4'h0;
			tx_sh_r <= `SPP_WORD_RST;
			rx_sh_r <= `SPP_WORD_RST;
			out_r <= 1'b0;
			oe_r <= 1'b0;
			rx_r <= '0;
			buf_r <= `SPP_WORD_RST;
			buf_full_r <= 1'b0;
			under_r <= 1'b0;
			per_cnt_r <= `SPP_PER_RST;
			seen_r <= 1'b0;
			err_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			sck_d_r <= sck_d_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			tx_sh_r <= tx_sh_nxt;
			rx_sh_r <= rx_sh_nxt;
			out_r <= out_nxt;
			oe_r <= oe_nxt;
			rx_r <= rx_nxt;
			buf_r <= buf_nxt;
			buf_full_r <= buf_full_nxt;
			under_r <= under_nxt;
			per_cnt_r <= per_cnt_nxt;
			seen_r <= seen_nxt;
			err_r <= err_nxt;
		end
	end

	assign device_to_host_data = out_r;
	assign device_to_host_data_oe = oe_r;
	assign rx_data = rx_r.data;
	assign rx_valid = rx_r.valid;
	assign tx_underrun = under_r;
	assign period_err = err_r;

endmodule

// File: tb/spp_port_properties.sv
`timescale 1ns/100ps
module spp_port_properties (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [31:0] global_control_reg,
	input wire logic [31:0] format_reg,
	input wire logic serial_clock_in,
	input wire logic chip_select_n,
	input wire logic device_to_host_data,
	input wire logic device_to_host_data_oe,
	input wire logic rx_valid,
	input wire logic period_err
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// Launch level: high means rising edge launches
	logic lvl;
	assign lvl = format_reg[17] ~^ format_reg[16];
	a_desel_release: assert property (chip_select_n [*4] |-> !device_to_host_data_oe)
		else $error("oe while deselected");
	a_ctrl_release: assert property (global_control_reg[0] [*4] |-> !device_to_host_data_oe)
		else $error("oe in controller mode");
	a_sel_drive: assert property ((!chip_select_n && !global_control_reg[0]) [*5]
		|-> device_to_host_data_oe)
		else $error("no oe when selected");
	// Window 2..5 allows one cycle of slack on the pin synchroniser
	a_launch_edge: assert property ($changed(device_to_host_data) &&
		device_to_host_data_oe && $past(device_to_host_data_oe)
		|-> $past(serial_clock_in, 2) == lvl && $past(serial_clock_in, 5) != lvl)
		else $error("data moved off launch edge");
	a_sample_edge: assert property (rx_valid |->
		$past(serial_clock_in, 2) != lvl && $past(serial_clock_in, 5) == lvl)
		else $error("word ended off sample edge");
	a_rx_in_frame: assert property (rx_valid |-> !$past(chip_select_n, 4))
		else $error("word while deselected");
	a_err_on_rise: assert property ($rose(period_err) |->
		$past(serial_clock_in, 2) && !$past(serial_clock_in, 5) && !$past(chip_select_n, 4))
		else $error("period error off rising edge");
	c_word: cover property (rx_valid);
	c_err: cover property ($rose(period_err));
	c_ctrl: cover property (global_control_reg[0] && !chip_select_n);
endmodule
bind spp_port spp_port_properties u_spp_port_properties (.clk, .arst_n, .global_control_reg,
	.format_reg, .serial_clock_in, .chip_select_n, .device_to_host_data,
	.device_to_host_data_oe, .rx_valid, .period_err);

// File: tb/spp_host_model.sv
`timescale 1ns/100ps
module spp_host_model (
	input wire logic clk,
	input wire logic miso,
	output logic sck,
	output logic cs_n,
	output logic mosi
);
	initial
	begin
		sck = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end
	// One framed transfer; nb below 16 aborts mid-word
	task automatic frame(input logic pol, input logic pha, input int hf, input int nb,
		input logic [15:0] wo, output logic [15:0] wi);
		wi = 16'h0000;
		@(posedge clk);
		sck <= pol;
		@(posedge clk);
		cs_n <= 1'b0;
		repeat (4 * hf) @(posedge clk);
		// Host data moves on the device's launch edge, away from its sample edge
		for (int i = 0; i < nb; i++)
		begin
			if (pha)
				mosi <= wo[15 - i];
			repeat (hf) @(posedge clk);
			if (pha)
				wi = {wi[14:0], miso};
			else
				mosi <= wo[15 - i];
			sck <= ~pol;
			repeat (hf) @(posedge clk);
			if (!pha)
				wi = {wi[14:0], miso};
			sck <= pol;
		end
		repeat (hf) @(posedge clk);
		cs_n <= 1'b1;
		mosi <= ~mosi;
		repeat (8) @(posedge clk);
	endtask
endmodule

// File: tb/spp_port_tb.sv
`timescale 1ns/100ps
module spp_port_tb;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [31:0] gcr = 32'h0;
	logic [31:0] fmt = 32'h0;
	logic [15:0] tx_data = 16'h0;
	logic tx_valid = 1'b0;
	logic err_clr = 1'b0;
	logic sck, cs_n, mosi, d2h, oe, tx_ready, rx_valid, period_err, under;
	logic [15:0] rx_data, got;
	// Released line shows the inverse, never a stale bit
	wire miso = oe ? d2h : ~d2h;
	int bad_count = 0;
	int n_checks = 0;
	int n_under = 0;
	always #5 clk = ~clk;
	always @(posedge clk)
		if (under === 1'b1)
			n_under++;
	spp_port u_spp_port (.clk, .arst_n, .global_control_reg(gcr), .format_reg(fmt),
		.serial_clock_in(sck), .chip_select_n(cs_n), .host_to_device_data(mosi),
		.device_to_host_data(d2h), .device_to_host_data_oe(oe), .tx_data, .tx_valid,
		.tx_ready, .rx_data, .rx_valid, .tx_underrun(under), .period_err, .err_clr);
	spp_host_model u_spp_host_model (.clk, .miso, .sck, .cs_n, .mosi);
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks=%0d mismatches=%0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic load(input logic [15:0] w);
		@(negedge clk);
		chk({15'h0, tx_ready}, 16'h0001);
		@(posedge clk);
		tx_data <= w;
		tx_valid <= 1'b1;
		@(posedge clk);
		tx_valid <= 1'b0;
	endtask
	task automatic t_modes;
		for (int m = 0; m < 4; m++)
		begin
			fmt <= {14'h0, m[1:0], 16'h0400};
			load(16'ha5c3 ^ m[15:0]);
			u_spp_host_model.frame(m[1], m[0], 6, 16, 16'h3c96 + m[15:0], got);
			chk(got, 16'ha5c3 ^ m[15:0]);
			chk(rx_data, 16'h3c96 + m[15:0]);
			chk({15'h0, period_err}, 16'h0000);
		end
	endtask
	task automatic t_ctrl_partial;
		int u0;
		gcr <= 32'h1;
		u_spp_host_model.frame(1'b1, 1'b1, 6, 16, 16'h1234, got);
		chk(rx_data, 16'h3c99);
		u0 = n_under;
		gcr <= 32'h0;
		u_spp_host_model.frame(1'b1, 1'b1, 6, 9, 16'hffff, got);
		chk(rx_data, 16'h3c99);
		u_spp_host_model.frame(1'b1, 1'b1, 6, 16, 16'h0f0f, got);
		chk(rx_data, 16'h0f0f);
		chk(got, 16'h0000);
		chk(16'(n_under - u0), 16'h0003);
	endtask
	// Prescale 20 is too slow for this clock; prescale 0 flags every period, since its two-cycle demand sits under the three-cycle floor
	task automatic t_period;
		for (int k = 0; k < 2; k++)
		begin
			@(posedge clk);
			fmt <= (k == 0) ? 32'h0003_1400 : 32'h0000_0000;
			u_spp_host_model.frame(k == 0, k == 0, 6, 16, 16'h5aa5 ^ k[15:0], got);
			chk({15'h0, period_err}, 16'h0001);
			chk(rx_data, 16'h5aa5 ^ k[15:0]);
			err_clr <= 1'b1;
			@(posedge clk);
			err_clr <= 1'b0;
			@(negedge clk);
			chk({15'h0, period_err}, 16'h0000);
		end
	endtask
	initial
	begin
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_modes;
		t_ctrl_partial;
		t_period;
		tally_and_finish;
	end
endmodule
